/* File: control_mode_pin_mux.sv */
/*
  Control-mode selection and multifunction pin multiplexing.
  Power-on straps are caught once after reset; shared pins then carry
  either live configuration levels or the serial port and eight I/O.
  Assumes pins are asynchronous to SYS_CLK and that the serial clock is
  a separate domain that stops outside frames.
*/
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "control_mode_params.svh"
module control_mode_pin_mux (
  // System clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // Power-on straps
  input  wire logic       CONTROL_SELECT,
  input  wire logic       RATE_MASTER_SELECT,
  input  wire logic       CLOCK_SOURCE_SELECT,
  // Multifunction pins
  input  wire logic       FORMAT0_OR_CHIP_SELECT,
  input  wire logic       FORMAT1_OR_SERIAL_CLOCK,
  input  wire logic       DECIM0_OR_CLOCK_DIRECTION,
  input  wire logic       DECIM1_OR_CLOCK_GATING,
  input  wire logic       DECIM2_OR_SERIAL_IN,
  input  wire logic       DECIM3_OR_SERIAL_OUT_IN,
  output logic            DECIM3_OR_SERIAL_OUT_OUT,
  output logic            DECIM3_OR_SERIAL_OUT_OE,
  // Clock rate, power, filter, frame pins as I/O 0 to 7
  input  wire logic [7:0] IO_PIN_IN,
  output logic      [7:0] IO_PIN_OUT,
  output logic      [7:0] IO_PIN_OE,
  // Local register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Configuration to the converter core
  output logic            SERIAL_MODE,
  output logic            RATE_MASTER,
  output logic            RATE_STROBE_OE,
  output logic            DATA_CLOCK_OE,
  output logic            DATA_CLOCK_FREE_RUN,
  output logic            CLOCK_OUT_EN,
  output logic      [1:0] FORMAT_SEL,
  output logic      [3:0] DECIM_SEL,
  output logic      [2:0] CLOCK_RATE_SEL,
  output logic            POWER_HIGH,
  output logic      [1:0] FILTER_SEL,
  output logic      [1:0] FRAME_SEL
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_b_reg;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_b_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_b_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [16:0] pin_raw;
  logic [16:0] pin_q;

  assign pin_raw = {IO_PIN_IN, DECIM3_OR_SERIAL_OUT_IN, DECIM2_OR_SERIAL_IN,
                    DECIM1_OR_CLOCK_GATING, DECIM0_OR_CLOCK_DIRECTION,
                    FORMAT1_OR_SERIAL_CLOCK, FORMAT0_OR_CHIP_SELECT,
                    CLOCK_SOURCE_SELECT, RATE_MASTER_SELECT, CONTROL_SELECT};

  pin_sync #(.WIDTH(17)) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_b (rst_b_reg),
    .d     (pin_raw),
    .q     (pin_q)
  );

  logic       s_control;
  logic       s_master;
  logic       s_clksrc;
  logic [1:0] s_format;
  logic [3:0] s_decim;
  logic [7:0] s_io;

  assign s_control = pin_q[0];
  assign s_master  = pin_q[1];
  assign s_clksrc  = pin_q[2];
  assign s_format  = pin_q[4:3];
  assign s_decim   = pin_q[8:5];
  assign s_io      = pin_q[16:9];

  // ----------------------------------------------------------------
  // Power-on strap capture
  // ----------------------------------------------------------------
  control_mode_pkg::strap_state_t strap_state_reg;
  logic [1:0] settle_reg;
  logic       serial_mode_reg;
  logic       master_reg;
  logic       crystal_reg;
  logic       dir_strap_reg;
  logic       gate_strap_reg;
  logic       captured;

  assign captured = (strap_state_reg == control_mode_pkg::ST_RUN);

  // Waits until the synchroniser has seen settled pins after release
  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      strap_state_reg <= control_mode_pkg::ST_WAIT;
      settle_reg      <= 2'h0;
    end else begin
      unique case (strap_state_reg)
        control_mode_pkg::ST_WAIT: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == `STRAP_SETTLE) begin
            strap_state_reg <= control_mode_pkg::ST_CAPTURE;
          end
        end
        control_mode_pkg::ST_CAPTURE: begin
          strap_state_reg <= control_mode_pkg::ST_RUN;
        end
        control_mode_pkg::ST_RUN: begin
          strap_state_reg <= control_mode_pkg::ST_RUN;
        end
        default: begin
          strap_state_reg <= control_mode_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // Later strap changes are ignored until the next reset
  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      serial_mode_reg <= 1'b0;
      master_reg      <= 1'b0;
      crystal_reg     <= 1'b0;
      dir_strap_reg   <= 1'b0;
      gate_strap_reg  <= 1'b0;
    end else if (strap_state_reg == control_mode_pkg::ST_CAPTURE) begin
      serial_mode_reg <= s_control;
      master_reg      <= s_master;
      crystal_reg     <= s_clksrc;
      dir_strap_reg   <= s_decim[0];
      gate_strap_reg  <= s_decim[1];
    end
  end

  // ----------------------------------------------------------------
  // Serial control port on the serial clock
  // ----------------------------------------------------------------
  logic        link_arst_b;
  logic [15:0] cmd_word;
  logic        req_tgl;
  logic        req_tgl_q;
  logic        req_seen_reg;
  logic        req_pulse;
  logic [7:0]  rd_hold_reg;
  logic        sdo_bit;
  logic        sdo_en;

  // Port held idle in pin mode; independent of data clock and strobe
  assign link_arst_b = rst_b_reg & serial_mode_reg & ~FORMAT0_OR_CHIP_SELECT;

  serial_shift u_serial_shift (
    .sclk        (FORMAT1_OR_SERIAL_CLOCK),
    .arst_b      (link_arst_b),
    .rst_b       (rst_b_reg),
    .sdi         (DECIM2_OR_SERIAL_IN),
    .sdo_reg     (sdo_bit),
    .sdo_oe_reg  (sdo_en),
    .cmd_reg     (cmd_word),
    .req_tgl_reg (req_tgl),
    .rd_word     (rd_hold_reg)
  );

  pin_sync #(.WIDTH(1)) u_req_sync (
    .clk   (SYS_CLK),
    .rst_b (rst_b_reg),
    .d     (req_tgl),
    .q     (req_tgl_q)
  );

  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      req_seen_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_tgl_q;
    end
  end

  // Command word is stable for a whole frame after the toggle
  assign req_pulse = (req_seen_reg != req_tgl_q) & serial_mode_reg;

  logic       ser_wr;
  logic       ser_rd;
  logic [3:0] ser_addr;

  assign ser_wr   = req_pulse & ~cmd_word[`CMD_READ_BIT] & (cmd_word[14:11] == 4'h0);
  assign ser_rd   = req_pulse & cmd_word[`CMD_READ_BIT];
  assign ser_addr = (cmd_word[14:11] == 4'h0) ? cmd_word[11:8] : 4'hF;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  control_mode_pkg::reg_byte_t io_out_reg;
  control_mode_pkg::reg_byte_t io_dir_reg;
  control_mode_pkg::reg_byte_t cfg_a_reg;
  control_mode_pkg::reg_byte_t cfg_b_reg;

  // Local port wins when both ports write in one cycle
  function automatic logic [1:0] wr_hit(input logic [3:0] target);
    wr_hit = {REG_WR & (REG_ADDR == target), ser_wr & (ser_addr == target)};
  endfunction

  function automatic logic [7:0] wr_pick(input logic [1:0] hit,
                                         input logic [7:0] old);
    wr_pick = hit[1] ? REG_WDATA : (hit[0] ? cmd_word[7:0] : old);
  endfunction

  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      io_out_reg <= `RST_IO_OUT;
      io_dir_reg <= `RST_IO_DIR;
      cfg_a_reg  <= `RST_SERIAL_CFG_A;
      cfg_b_reg  <= `RST_SERIAL_CFG_B;
    end else begin
      io_out_reg <= wr_pick(wr_hit(`REG_IO_OUT), io_out_reg);
      io_dir_reg <= wr_pick(wr_hit(`REG_IO_DIR), io_dir_reg);
      cfg_a_reg  <= wr_pick(wr_hit(`REG_SERIAL_CFG_A), cfg_a_reg);
      cfg_b_reg  <= wr_pick(wr_hit(`REG_SERIAL_CFG_B), cfg_b_reg);
    end
  end

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  logic       pin_master;
  logic [1:0] fmt_next;
  logic [3:0] dec_next;
  logic [2:0] rate_next;
  logic       pwr_next;
  logic [1:0] flt_next;
  logic [1:0] frm_next;
  logic       dir_next;
  logic       free_next;
  logic       buffered_clock_output_next;

  assign pin_master = ~serial_mode_reg & master_reg;

  always_comb begin
    if (!captured) begin
      fmt_next  = 2'h0;
      dec_next  = 4'h0;
      rate_next = 3'h0;
      pwr_next  = 1'b0;
      flt_next  = 2'h0;
      frm_next  = 2'h0;
    end else if (!serial_mode_reg) begin
      fmt_next  = s_format;
      dec_next  = master_reg ? s_decim : {s_decim[3:2], 2'h0};
      rate_next = s_io[2:0];
      pwr_next  = s_io[3];
      flt_next  = s_io[5:4];
      frm_next  = s_io[7:6];
    end else begin
      fmt_next  = cfg_a_reg[`CFG_A_FORMAT_LSB +: 2];
      dec_next  = cfg_b_reg[`CFG_B_DECIM_LSB +: 4];
      rate_next = cfg_b_reg[`CFG_B_RATE_LSB +: 3];
      pwr_next  = cfg_a_reg[`CFG_A_POWER_BIT];
      flt_next  = cfg_a_reg[`CFG_A_FILTER_LSB +: 2];
      frm_next  = cfg_a_reg[`CFG_A_FRAME_LSB +: 2];
    end
  end

  always_comb begin
    // Pin master forces output; pin slave forces input whatever the strap
    dir_next    = captured & (pin_master | (serial_mode_reg & dir_strap_reg));
    // Pin master offers only a gated data clock
    free_next   = captured & ~pin_master & gate_strap_reg;
    buffered_clock_output_next = captured & crystal_reg &
                  (~serial_mode_reg | cfg_b_reg[`CFG_B_BUFFERED_CLOCK_OUTPUT_BIT]);
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      SERIAL_MODE         <= 1'b0;
      RATE_MASTER         <= 1'b0;
      RATE_STROBE_OE      <= 1'b0;
      DATA_CLOCK_OE       <= 1'b0;
      DATA_CLOCK_FREE_RUN <= 1'b0;
      CLOCK_OUT_EN        <= 1'b0;
      FORMAT_SEL          <= 2'h0;
      DECIM_SEL           <= 4'h0;
      CLOCK_RATE_SEL      <= 3'h0;
      POWER_HIGH          <= 1'b0;
      FILTER_SEL          <= 2'h0;
      FRAME_SEL           <= 2'h0;
    end else begin
      SERIAL_MODE         <= captured & serial_mode_reg;
      RATE_MASTER         <= captured & master_reg;
      RATE_STROBE_OE      <= captured & master_reg;
      DATA_CLOCK_OE       <= dir_next;
      DATA_CLOCK_FREE_RUN <= free_next;
      CLOCK_OUT_EN        <= buffered_clock_output_next;
      FORMAT_SEL          <= fmt_next;
      DECIM_SEL           <= dec_next;
      CLOCK_RATE_SEL      <= rate_next;
      POWER_HIGH          <= pwr_next;
      FILTER_SEL          <= flt_next;
      FRAME_SEL           <= frm_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic sdo_q;
  logic sdo_oe_q;

  // Serial out and its enable both stay on the serial clock, retimed on its falling edge
  assign DECIM3_OR_SERIAL_OUT_OUT = sdo_q;
  assign DECIM3_OR_SERIAL_OUT_OE  = sdo_oe_q;

  always_ff @(negedge FORMAT1_OR_SERIAL_CLOCK or negedge link_arst_b) begin
    if (!link_arst_b) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q    <= sdo_bit;
      sdo_oe_q <= sdo_en;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      IO_PIN_OUT <= 8'h00;
      IO_PIN_OE  <= 8'h00;
    end else begin
      IO_PIN_OUT <= io_out_reg;
      IO_PIN_OE  <= (captured & serial_mode_reg) ? io_dir_reg : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [3:0] idx);
    unique case (idx)
      `REG_STATUS:       reg_read = {2'h0, serial_mode_reg, master_reg, crystal_reg,
                                     dir_strap_reg, gate_strap_reg, captured};
      `REG_EFFECT_A:     reg_read = {1'b0, POWER_HIGH, FRAME_SEL, FILTER_SEL, FORMAT_SEL};
      `REG_EFFECT_B:     reg_read = {CLOCK_OUT_EN, CLOCK_RATE_SEL, DECIM_SEL};
      `REG_IO_OUT:       reg_read = io_out_reg;
      `REG_IO_DIR:       reg_read = io_dir_reg;
      `REG_IO_IN:        reg_read = s_io;
      `REG_SERIAL_CFG_A: reg_read = cfg_a_reg;
      `REG_SERIAL_CFG_B: reg_read = cfg_b_reg;
      default:           reg_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= REG_RD ? reg_read(REG_ADDR) : 8'h00;
    end
  end

  // Answer to a serial read is shifted out in the following frame
  always_ff @(posedge SYS_CLK or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      rd_hold_reg <= 8'h00;
    end else if (ser_rd) begin
      rd_hold_reg <= reg_read(ser_addr);
    end
  end
endmodule

/* File: control_mode_params.svh */
/*
  Constants for the control-mode and multifunction pin block: register
  indices, field positions, reset values and the power-on strap settle count.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef CONTROL_MODE_PARAMS_SVH
`define CONTROL_MODE_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices on the local port and the serial port
// ----------------------------------------------------------------
`define REG_STATUS       4'h0
`define REG_EFFECT_A     4'h1
`define REG_EFFECT_B     4'h2
`define REG_IO_OUT       4'h3
`define REG_IO_DIR       4'h4
`define REG_IO_IN        4'h5
`define REG_SERIAL_CFG_A 4'h6
`define REG_SERIAL_CFG_B 4'h7
`define REG_COUNT        8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFG_A_FORMAT_LSB 0
`define CFG_A_FILTER_LSB 2
`define CFG_A_FRAME_LSB  4
`define CFG_A_POWER_BIT  6
`define CFG_B_DECIM_LSB  0
`define CFG_B_RATE_LSB   4
`define CFG_B_BUFFERED_CLOCK_OUTPUT_BIT 7
`define CMD_READ_BIT     15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_IO_OUT       8'h00
`define RST_IO_DIR       8'h00
`define RST_SERIAL_CFG_A 8'h40
`define RST_SERIAL_CFG_B 8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STRAP_SETTLE     2'h3
`define FRAME_BITS       5'h10

`endif

/* File: control_mode_pkg.sv */
/*
  Types shared by the control-mode block.
  Assumes nothing of its surroundings.
*/
package control_mode_pkg;
  typedef enum logic [1:0] {ST_WAIT, ST_CAPTURE, ST_RUN} strap_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

/* File: pin_sync.sv */
/*
  Two-flop synchroniser for a vector of unrelated levels.
  Assumes each bit is an independent level; no bus coherence is implied.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[i] <= 1'b0;
          q[i]        <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          q[i]        <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

/* File: serial_shift.sv */
/*
  Serial control shifter on the host serial clock.
  Assumes chip select high (or pin mode) holds arst_b low between frames,
  and that frames are spaced so the system side sees every request.
*/
`timescale 1ns/1ns
`include "control_mode_params.svh"
module serial_shift (
  // Link clock and resets
  input  wire logic        sclk,
  input  wire logic        arst_b,
  input  wire logic        rst_b,
  // Serial pins
  input  wire logic        sdi,
  output logic             sdo_reg,
  output logic             sdo_oe_reg,
  // Toward the system domain
  output logic [15:0]      cmd_reg,
  output logic             req_tgl_reg,
  input  wire logic [7:0]  rd_word
);
  logic [4:0]  cnt_reg;
  logic [14:0] shift_reg;
  logic [6:0]  out_reg;

  // Frame position, cleared whenever chip select rises
  always_ff @(posedge sclk or negedge arst_b) begin
    if (!arst_b) begin
      cnt_reg    <= 5'h00;
      shift_reg  <= 15'h0000;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= 1'b1;
      if (cnt_reg != `FRAME_BITS) begin
        cnt_reg   <= cnt_reg + 5'h01;
        shift_reg <= {shift_reg[13:0], sdi};
      end
    end
  end

  // Read data from the previous read, stable since that frame ended
  always_ff @(posedge sclk or negedge arst_b) begin
    if (!arst_b) begin
      sdo_reg <= 1'b0;
      out_reg <= 7'h00;
    end else if (cnt_reg == 5'h07) begin
      sdo_reg <= rd_word[7];
      out_reg <= rd_word[6:0];
    end else begin
      sdo_reg <= out_reg[6];
      out_reg <= {out_reg[5:0], 1'b0};
    end
  end

  // Command survives chip select so the other domain can pick it up
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg     <= 16'h0000;
      req_tgl_reg <= 1'b0;
    end else if (cnt_reg == 5'h0F) begin
      cmd_reg     <= {shift_reg, sdi};
      req_tgl_reg <= ~req_tgl_reg;
    end
  end
endmodule

/* File: control_mode_chk.sv */
/*
  Assertion checker for the control-mode pin block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module control_mode_chk (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RST_B,
  // Watched ports
  input wire logic       FORMAT0_OR_CHIP_SELECT,
  input wire logic       DECIM3_OR_SERIAL_OUT_OE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [7:0] IO_PIN_OUT,
  input wire logic [7:0] IO_PIN_OE,
  input wire logic       SERIAL_MODE,
  input wire logic       RATE_MASTER,
  input wire logic       RATE_STROBE_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ----
  // Properties
  // ----
  sequence s_io_write;
    REG_WR && REG_ADDR == 4'h3 ##1 1'b1;
  endsequence
  property p_mode_held;
    SERIAL_MODE |=> SERIAL_MODE;
  endproperty
  property p_master_held;
    RATE_MASTER |=> RATE_MASTER;
  endproperty
  property p_strobe_dir;
    RATE_STROBE_OE == RATE_MASTER;
  endproperty
  property p_io_oe_pin;
    !SERIAL_MODE |-> IO_PIN_OE == 8'h00;
  endproperty
  property p_sdo_quiet;
    !SERIAL_MODE |-> !DECIM3_OR_SERIAL_OUT_OE;
  endproperty
  property p_cs_release;
    SERIAL_MODE && $rose(FORMAT0_OR_CHIP_SELECT) |-> ##[1:3] !DECIM3_OR_SERIAL_OUT_OE;
  endproperty
  property p_rd_idle;
    !REG_RD |=> REG_RDATA == 8'h00;
  endproperty
  property p_rd_unmapped;
    REG_RD && REG_ADDR[3] |=> REG_RDATA == 8'h00;
  endproperty
  property p_io_write;
    s_io_write |=> IO_PIN_OUT == $past(REG_WDATA, 2);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("control mode changed after capture");
  a_master_held: assert property (p_master_held)
    else $error("rate master changed after capture");
  a_strobe_dir: assert property (p_strobe_dir)
    else $error("rate strobe direction wrong");
  a_io_oe_pin: assert property (p_io_oe_pin)
    else $error("io driven in pin mode");
  a_sdo_quiet: assert property (p_sdo_quiet)
    else $error("serial out driven in pin mode");
  a_cs_release: assert property (p_cs_release)
    else $error("serial out held after chip select");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_io_write: assert property (p_io_write)
    else $error("io output not updated");
endmodule

/* File: serial_host_model.sv */
/*
  Model of the host serial control master.
  Assumes the bench routes its pins to the block in serial mode.
*/
`timescale 1ns/1ns
module serial_host_model (
  // Serial pins
  output logic      cs_b,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // Clock runs only inside a frame, on its own timing
  task automatic frame(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    cs_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #6 sclk = 1'b1;
      if (i < 8)
        r[i] = sdo;
      #6 sclk = 1'b0;
    end
    #6 cs_b = 1'b1;
    // Released line must not keep its last level
    sdi = ~sdi;
  endtask
endmodule

/* File: testbench.sv */
/*
  Self-checking bench for the control-mode pin block.
  Assumes the checker and host model are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rst_b;
  logic        ser;
  logic [2:0]  strap;
  logic [5:0]  pinv;
  logic [7:0]  io_in, io_out, io_oe;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv, a, b;
  logic        reg_wr, reg_rd, rd_seen;
  logic        sdo_out, sdo_oe, h_cs_b, h_sclk, h_sdi;
  wire         d3_wire;
  logic [5:0]  mode_o;
  logic [13:0] cfg_o;
  logic [7:0]  expq[$];
  int          fail_count, checks_done;

  assign d3_wire = sdo_oe ? sdo_out : pinv[5];

  control_mode_pin_mux i_dut (
    .SYS_CLK(clk), .RST_B(rst_b), .CONTROL_SELECT(strap[2]),
    .RATE_MASTER_SELECT(strap[1]), .CLOCK_SOURCE_SELECT(strap[0]),
    .FORMAT0_OR_CHIP_SELECT(ser ? h_cs_b : pinv[0]),
    .FORMAT1_OR_SERIAL_CLOCK(ser ? h_sclk : pinv[1]),
    .DECIM0_OR_CLOCK_DIRECTION(pinv[2]), .DECIM1_OR_CLOCK_GATING(pinv[3]),
    .DECIM2_OR_SERIAL_IN(ser ? h_sdi : pinv[4]), .DECIM3_OR_SERIAL_OUT_IN(d3_wire),
    .DECIM3_OR_SERIAL_OUT_OUT(sdo_out), .DECIM3_OR_SERIAL_OUT_OE(sdo_oe),
    .IO_PIN_IN(io_in), .IO_PIN_OUT(io_out), .IO_PIN_OE(io_oe),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .SERIAL_MODE(mode_o[5]), .RATE_MASTER(mode_o[4]),
    .RATE_STROBE_OE(mode_o[3]), .DATA_CLOCK_OE(mode_o[2]),
    .DATA_CLOCK_FREE_RUN(mode_o[1]), .CLOCK_OUT_EN(mode_o[0]),
    .FORMAT_SEL(cfg_o[13:12]), .DECIM_SEL(cfg_o[11:8]), .CLOCK_RATE_SEL(cfg_o[7:5]),
    .POWER_HIGH(cfg_o[4]), .FILTER_SEL(cfg_o[3:2]), .FRAME_SEL(cfg_o[1:0]));

  serial_host_model i_host (.cs_b(h_cs_b), .sclk(h_sclk), .sdi(h_sdi), .sdo(d3_wire));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [2:0] s, input logic [5:0] p);
    rst_b <= 1'b0;
    strap <= s;
    pinv  <= p;
    ser   <= s[2];
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic r, input logic [3:0] ad,
                     input logic [7:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, 1'b1, ad, 8'h00);
  endtask
  task automatic hframe(input logic [15:0] w);
    @(posedge clk);
    #3 i_host.frame(w, rv);
    repeat (8) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read data noted at the request, compared when it appears
  always @(negedge clk) begin
    if (rd_seen)
      cmp(reg_rdata, expq.pop_front());
    rd_seen = reg_rd;
  end

  initial begin
    #50000;
    fail_count++;
    complete_run();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'hD6D6));
    {reg_wr, reg_rd, reg_addr, reg_wdata, io_in} = '0;
    start(3'b011, 6'h04);
    rd(4'h0, 8'h1D);
    rd(4'h9, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    cmp(mode_o, 6'h1D);
    repeat (8) begin
      pinv  <= 6'($urandom);
      io_in <= 8'($urandom);
      repeat (6) @(posedge clk);
      cmp(cfg_o, {pinv[1:0], pinv[5:2], io_in[2:0], io_in[3], io_in[5:4], io_in[7:6]});
      cmp(io_oe, 8'h00);
    end
    strap <= 3'b100;
    repeat (6) @(posedge clk);
    cmp(mode_o, 6'h1D);
    start(3'b000, 6'h08);
    rd(4'h0, 8'h03);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    cmp(mode_o, 6'h02);
    pinv <= 6'h3B;
    repeat (6) @(posedge clk);
    cmp(cfg_o[11:8], 4'hC);
    start(3'b101, 6'h04);
    cmp(mode_o, 6'h25);
    cmp(cfg_o, 14'h0010);
    bus(1'b1, 1'b0, 4'h1, 8'hFF);
    bus(1'b1, 1'b0, 4'h9, 8'hFF);
    rd(4'h0, 8'h2D);
    rd(4'h1, 8'h40);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h6, 8'h40);
    rd(4'h7, 8'h80);
    rd(4'h9, 8'h00);
    a = 8'($urandom);
    b = 8'($urandom);
    bus(1'b1, 1'b0, 4'h3, a);
    bus(1'b1, 1'b0, 4'h4, b);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    io_in <= 8'($urandom);
    repeat (5) @(posedge clk);
    cmp(io_out, a);
    cmp(io_oe, b);
    rd(4'h5, io_in);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    a = 8'($urandom) & 8'h7F;
    b = 8'($urandom);
    hframe({8'h06, a});
    hframe({8'h07, b});
    cmp(cfg_o, {a[1:0], b[3:0], b[6:4], a[6], a[3:2], a[5:4]});
    cmp(mode_o, {5'h12, b[7]});
    hframe({8'h86, 8'h00});
    hframe({8'h80, 8'h00});
    cmp(rv, a);
    complete_run();
  end
endmodule

bind control_mode_pin_mux control_mode_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .FORMAT0_OR_CHIP_SELECT(FORMAT0_OR_CHIP_SELECT),
  .DECIM3_OR_SERIAL_OUT_OE(DECIM3_OR_SERIAL_OUT_OE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .IO_PIN_OUT(IO_PIN_OUT), .IO_PIN_OE(IO_PIN_OE), .SERIAL_MODE(SERIAL_MODE),
  .RATE_MASTER(RATE_MASTER), .RATE_STROBE_OE(RATE_STROBE_OE));
